// file: common/mdpm_map.vh
// Constants for the mode dependent port pin multiplexer.
// Assumes an 8-bit core register interface of plain ports.
`ifndef MDPM_MAP_VH
`define MDPM_MAP_VH
`define MDPM_MODE_BOOT      2'h0
`define MDPM_MODE_SINGLE    2'h1
`define MDPM_MODE_TEST      2'h2
`define MDPM_MODE_EXPANDED  2'h3
`define MDPM_ACCUMULATOR_CONTROL_REGISTER_DIR7     7
`define MDPM_ACCUMULATOR_CONTROL_REGISTER_DIR3     3
`define MDPM_ACCUMULATOR_CONTROL_REGISTER_RESET    8'h00
`define MDPM_TPORT_RESET    8'h00
`define MDPM_HPORT_RESET    8'h00
`define MDPM_CPORT_RESET    8'h00
`define MDPM_CDIR_RESET     8'h00
`define MDPM_DPORT_RESET    6'h00
`define MDPM_DDIR_RESET     6'h00
`define MDPM_STROBE_NS      20
`define MDPM_STROBE_CYC     ((`MDPM_STROBE_NS * 50 + 999) / 1000)
`endif

// file: hw/mdpm_edge_latch.v
// Input strobe edge detector and latched input register.
// Assumes the strobe and data inputs are synchronous to clk.
`timescale 1ns/100ps
`include "mdpm_map.vh"
module mdpm_edge_latch (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       enable,
	input  wire       edge_rising,
	input  wire       strobe_in,
	input  wire [7:0] data_in,
	output reg  [7:0] latched_q,
	output reg        event_q
);
	reg strobe_q;
	wire hit;
	assign hit = enable & (edge_rising ? (strobe_in & ~strobe_q) : (~strobe_in & strobe_q));
	always @(posedge clk) begin
		if (!rst_b) begin
			// Track the pin in reset so its idle level gives no false edge
			strobe_q  <= strobe_in;
			latched_q <= 8'h00;
			event_q   <= 1'b0;
		end else begin
			strobe_q <= strobe_in;
			event_q  <= hit;
			if (hit) begin
				latched_q <= data_in;
			end
		end
	end
endmodule

// file: hw/mdpm_port_mux.v
// Port pin multiplexer: timer, high address, multiplexed, serial and analog ports.
// Assumes a core that drives register writes as one-cycle strobes and a bus sequencer.
`timescale 1ns/100ps
`include "mdpm_map.vh"
// Operation
// - Timer port serves three captures, four compares, one shared capture/compare pin
// - Only timer pins 7 and 3 have direction bits in accumulator control register
// - Timer pin 7 always feeds the pulse accumulator input
// - Timer pins 6-4 are outputs or compares 2-4, also master compare
// - Timer pin 3 is I/O, master compare or shared channel, optional capture trigger
// - Timer pins 2-0 are only inputs or captures 1-3
// - Timer port reads pin level for inputs, driver input for outputs
// - Timer port writes latch bits 7 and 3; other timer bits ignore writes
// - Single-chip high address port is outputs, read back from driver input
// - Strobed output mode pulses output strobe on each high address port write
// - Expanded mode drives address 15-8 on high address port; its register is external
// - Single-chip multiplexed port latches inputs on input strobe transition
// - Full handshake transfers use input strobe in and output strobe out
// - Expanded mode drives address 7-0, then data while phase clock high, by read/write
// - Open-drain select makes all eight multiplexed pins drive only low
// - Open-drain behaviour only in single-chip mode
// - Serial pins are I/O unless serial enabled; pin 0 receive, pin 1 transmit
// - With SPI enabled pins 2-5 are MISO, MOSI, SCK and SS input
// - Mode is latched from the two mode inputs on the first clock after reset ends
// - Single-chip restricts to on-chip memory; expanded allows external accesses
// - Bootstrap is single-chip variant; test is expanded variant with privileges
// - Expanded mode uses input strobe pin as address latch strobe; here the strobe goes out on the separate address_latch_strobe output
// - Read/write low for writes, high for reads, low across consecutive writes
module mdpm_port_mux (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       mode_select_low,
	input  wire       mode_select_high,
	input  wire       wr_timer_port,
	input  wire       wr_accum_ctl,
	input  wire       wr_high_port,
	input  wire       wr_mux_port,
	input  wire       wr_mux_dir,
	input  wire       wr_serial_port,
	input  wire       wr_serial_dir,
	input  wire [7:0] wr_data,
	input  wire       open_drain_select,
	input  wire       strobed_mode,
	input  wire       handshake_mode,
	input  wire       strobe_edge_rising,
	input  wire       out_strobe_active_high,
	input  wire [7:0] timer_oc_en,
	input  wire [7:0] timer_oc_val,
	input  wire       shared_is_compare,
	input  wire       sci_enable,
	input  wire       sci_txd,
	input  wire       spi_enable,
	input  wire       spi_master,
	input  wire       spi_miso_out,
	input  wire       spi_mosi_out,
	input  wire       spi_sck_out,
	input  wire       bus_cycle,
	input  wire       bus_phase_clk,
	input  wire       bus_write,
	input  wire [15:0] bus_addr,
	input  wire [7:0] bus_wdata,
	input  wire [7:0] timer_pins_in,
	input  wire [7:0] mux_pins_in,
	input  wire [5:0] serial_pins_in,
	input  wire [7:0] analog_pins_in,
	input  wire       input_strobe_pin,
	output reg  [7:0] timer_pins_out,
	output reg  [7:0] timer_pins_oe,
	output reg  [7:0] high_pins_out,
	output reg  [7:0] mux_pins_out,
	output reg  [7:0] mux_pins_oe,
	output reg  [5:0] serial_pins_out,
	output reg  [5:0] serial_pins_oe,
	output reg        output_strobe_pin,
	output reg        address_latch_strobe,
	output reg  [7:0] timer_port_rd_q,
	output reg  [7:0] high_port_rd_q,
	output reg  [7:0] mux_port_rd_q,
	output reg  [7:0] latched_input_register,
	output reg  [5:0] serial_port_rd_q,
	output reg  [7:0] analog_port_rd_q,
	output reg        pulse_accumulator_input,
	output reg  [7:0] capture_inputs,
	output reg  [1:0] mode_q,
	output reg        expanded_q,
	output reg        special_q,
	output reg        bus_data_valid_q,
	output reg  [7:0] bus_rdata_q,
	output reg        high_port_external_q,
	output reg        handshake_flag_q
);
	reg  [7:0] tport_q;
	reg  [7:0] accumulator_control_register_q;
	reg  [7:0] hport_q;
	reg  [7:0] cport_q;
	reg  [7:0] cdir_q;
	reg  [5:0] dport_q;
	reg  [5:0] ddir_q;
	reg        in_reset_q;
	reg  [3:0] stb_cnt_q;
	reg  [3:0] stb_cnt_d;
	reg  [7:0] t_out_d;
	reg  [7:0] t_oe_d;
	reg  [7:0] c_out_d;
	reg  [7:0] c_oe_d;
	reg  [5:0] d_out_d;
	reg  [5:0] d_oe_d;
	wire [7:0] latched_w;
	wire       strobe_evt;
	wire       single_w;
	wire [7:0] tdir_w;
	wire [31:0] stb_cyc_w;
	integer    i;
	integer    j;

	// Single-chip style modes are boot and single; expanded style are test and expanded
	function is_expanded;
		input [1:0] m;
		begin
			is_expanded = m[1];
		end
	endfunction

	assign single_w = ~is_expanded(mode_q);
	assign stb_cyc_w = `MDPM_STROBE_CYC;
	// Fixed directions: 6-4 outputs, 2-0 inputs, 7 and 3 from direction bits
	assign tdir_w = {accumulator_control_register_q[`MDPM_ACCUMULATOR_CONTROL_REGISTER_DIR7], 3'h7, accumulator_control_register_q[`MDPM_ACCUMULATOR_CONTROL_REGISTER_DIR3], 3'h0};

	mdpm_edge_latch u_latch (
		.clk         (clk),
		.rst_b       (rst_b),
		.enable      (single_w),
		.edge_rising (strobe_edge_rising),
		.strobe_in   (input_strobe_pin),
		.data_in     (mux_pins_in),
		.latched_q   (latched_w),
		.event_q     (strobe_evt)
	);

	// Pin drive decisions
	always @* begin
		t_out_d = 8'h00;
		t_oe_d  = 8'h00;
		for (i = 0; i < 8; i = i + 1) begin
			if (i >= 3) begin
				if (timer_oc_en[i] && (i != 3 || shared_is_compare || timer_oc_en[i])) begin
					t_out_d[i] = timer_oc_val[i];
					t_oe_d[i]  = 1'b1;
				end else if (tdir_w[i]) begin
					t_out_d[i] = tport_q[i];
					t_oe_d[i]  = 1'b1;
				end
			end
		end
		t_oe_d[2:0] = 3'h0;
		c_out_d = 8'h00;
		c_oe_d  = 8'h00;
		if (!single_w) begin
			if (bus_cycle && !bus_phase_clk) begin
				c_out_d = bus_addr[7:0];
				c_oe_d  = 8'hff;
			end else if (bus_cycle && bus_write) begin
				c_out_d = bus_wdata;
				c_oe_d  = 8'hff;
			end
		end else begin
			for (i = 0; i < 8; i = i + 1) begin
				c_out_d[i] = cport_q[i];
				if (open_drain_select) begin
					c_oe_d[i] = cdir_q[i] & ~cport_q[i];
				end else begin
					c_oe_d[i] = cdir_q[i];
				end
			end
		end
		d_out_d = dport_q;
		d_oe_d  = ddir_q;
		if (sci_enable) begin
			d_oe_d[0]  = 1'b0;
			d_out_d[1] = sci_txd;
			d_oe_d[1]  = 1'b1;
		end
		if (spi_enable) begin
			d_out_d[2] = spi_miso_out;
			d_oe_d[2]  = ~spi_master;
			d_out_d[3] = spi_mosi_out;
			d_oe_d[3]  = spi_master;
			d_out_d[4] = spi_sck_out;
			d_oe_d[4]  = spi_master;
			d_oe_d[5]  = 1'b0;
		end
	end

	// Output strobe pulse counter
	always @* begin
		stb_cnt_d = (stb_cnt_q != 4'h0) ? stb_cnt_q - 4'h1 : 4'h0;
		if (single_w && strobed_mode && !handshake_mode && wr_high_port) begin
			stb_cnt_d = stb_cyc_w[3:0];
		end
	end

	always @(posedge clk) begin
		if (!rst_b) begin
			in_reset_q <= 1'b1;
			mode_q     <= `MDPM_MODE_SINGLE;
			accumulator_control_register_q    <= `MDPM_ACCUMULATOR_CONTROL_REGISTER_RESET;
			tport_q    <= `MDPM_TPORT_RESET;
			hport_q    <= `MDPM_HPORT_RESET;
			cport_q    <= `MDPM_CPORT_RESET;
			cdir_q     <= `MDPM_CDIR_RESET;
			dport_q    <= `MDPM_DPORT_RESET;
			ddir_q     <= `MDPM_DDIR_RESET;
			stb_cnt_q  <= 4'h0;
			handshake_flag_q <= 1'b0;
		end else begin
			in_reset_q <= 1'b0;
			if (in_reset_q) begin
				mode_q <= {mode_select_high, mode_select_low};
			end
			if (wr_accum_ctl) begin
				accumulator_control_register_q <= wr_data;
			end
			if (wr_timer_port) begin
				tport_q[7] <= wr_data[7];
				tport_q[3] <= wr_data[3];
			end
			if (wr_high_port && single_w) begin
				hport_q <= wr_data;
			end
			if (wr_mux_port) begin
				cport_q <= wr_data;
			end
			if (wr_mux_dir) begin
				cdir_q <= wr_data;
			end
			if (wr_serial_port) begin
				dport_q <= wr_data[5:0];
			end
			if (wr_serial_dir) begin
				ddir_q <= wr_data[5:0];
			end
			stb_cnt_q <= stb_cnt_d;
			// Handshake: strobe in sets ready flag, port write clears; set wins
			if (single_w && handshake_mode && strobe_evt) begin
				handshake_flag_q <= 1'b1;
			end else if (wr_mux_port) begin
				handshake_flag_q <= 1'b0;
			end
		end
	end

	// Registered pin and read outputs
	always @(posedge clk) begin
		if (!rst_b) begin
			timer_pins_out          <= 8'h00;
			timer_pins_oe           <= 8'h00;
			high_pins_out           <= 8'h00;
			mux_pins_out            <= 8'h00;
			mux_pins_oe             <= 8'h00;
			serial_pins_out         <= 6'h00;
			serial_pins_oe          <= 6'h00;
			output_strobe_pin       <= 1'b0;
			address_latch_strobe    <= 1'b0;
			timer_port_rd_q         <= 8'h00;
			high_port_rd_q          <= 8'h00;
			mux_port_rd_q           <= 8'h00;
			latched_input_register  <= 8'h00;
			serial_port_rd_q        <= 6'h00;
			analog_port_rd_q        <= 8'h00;
			pulse_accumulator_input <= 1'b0;
			capture_inputs          <= 8'h00;
			expanded_q              <= 1'b0;
			special_q               <= 1'b0;
			bus_data_valid_q        <= 1'b0;
			bus_rdata_q             <= 8'h00;
			high_port_external_q    <= 1'b0;
		end else begin
			timer_pins_out <= t_out_d;
			timer_pins_oe  <= t_oe_d;
			high_pins_out  <= single_w ? hport_q : bus_addr[15:8];
			mux_pins_out   <= c_out_d;
			mux_pins_oe    <= c_oe_d;
			serial_pins_out <= d_out_d;
			serial_pins_oe  <= d_oe_d;
			if (single_w) begin
				output_strobe_pin <= handshake_mode ? (handshake_flag_q ~^ out_strobe_active_high)
					: ((stb_cnt_d != 4'h0) ~^ out_strobe_active_high);
				address_latch_strobe <= 1'b0;
			end else begin
				output_strobe_pin    <= ~(bus_cycle & bus_write);
				address_latch_strobe <= bus_cycle & ~bus_phase_clk;
			end
			for (j = 0; j < 8; j = j + 1) begin
				timer_port_rd_q[j] <= t_oe_d[j] ? t_out_d[j] : timer_pins_in[j];
			end
			high_port_rd_q <= hport_q;
			mux_port_rd_q  <= mux_pins_in;
			latched_input_register <= latched_w;
			serial_port_rd_q <= serial_pins_in;
			analog_port_rd_q <= analog_pins_in;
			pulse_accumulator_input <= timer_pins_oe[7] ? timer_pins_out[7] : timer_pins_in[7];
			capture_inputs <= {4'h0, timer_pins_oe[3] ? timer_pins_out[3] : timer_pins_in[3],
				timer_pins_in[2:0]};
			expanded_q  <= ~single_w;
			special_q   <= ~mode_q[0];
			bus_data_valid_q <= ~single_w & bus_cycle & bus_phase_clk & ~bus_write;
			if (~single_w && bus_cycle && bus_phase_clk && !bus_write) begin
				bus_rdata_q <= mux_pins_in;
			end
			high_port_external_q <= ~single_w;
		end
	end
endmodule

// file: verif/mdpm_ext_mem.sv
// External memory on the multiplexed address and data bus.
// Assumes expanded mode timing from the pin multiplexer outputs.
`timescale 1ns/100ps
module mdpm_ext_mem (
	input  wire       clk,
	input  wire       enable,
	input  wire       address_latch_strobe,
	input  wire       output_strobe_pin,
	input  wire       bus_phase_clk,
	input  wire [7:0] mux_pins_out,
	input  wire [7:0] gpio_level,
	output wire [7:0] mux_pins_in
);
	reg  [7:0] mem [0:255];
	reg  [7:0] addr_q = 8'h00;
	reg  [7:0] last_q = 8'h00;
	wire       rd_w   = enable && bus_phase_clk && output_strobe_pin;
	// Released bus shows a toggling pattern while enabled, else the gpio_level input
	assign mux_pins_in = rd_w ? mem[addr_q] : (enable ? ~last_q : gpio_level);
	always @(posedge clk) begin
		if (enable && address_latch_strobe)
			addr_q <= mux_pins_out;
		if (enable && bus_phase_clk && !output_strobe_pin)
			mem[addr_q] <= mux_pins_out;
		last_q <= mux_pins_in;
	end
endmodule

// file: verif/mdpm_port_mux_asserts.sv
// Checker for the port pin multiplexer.
// Assumes it is bound to mdpm_port_mux and sees only its ports.
`timescale 1ns/100ps
module mdpm_port_mux_asserts (
	input wire        clk,
	input wire        rst_b,
	input wire        wr_high_port,
	input wire        strobed_mode,
	input wire        handshake_mode,
	input wire        out_strobe_active_high,
	input wire        open_drain_select,
	input wire        bus_cycle,
	input wire [15:0] bus_addr,
	input wire [7:0]  wr_data,
	input wire [7:0]  timer_pins_in,
	input wire [7:0]  timer_pins_oe,
	input wire [7:0]  high_pins_out,
	input wire [7:0]  mux_pins_out,
	input wire [7:0]  mux_pins_oe,
	input wire        output_strobe_pin,
	input wire        pulse_accumulator_input,
	input wire [1:0]  mode_q,
	input wire        expanded_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	mode_hold_a: assert property ($past(rst_b, 2) |-> $stable(mode_q))
		else $error("mode changed after reset");
	mode_flag_a: assert property ($past(rst_b, 3) |-> expanded_q == mode_q[1])
		else $error("expanded flag does not follow mode");
	fixed_input_a: assert property (timer_pins_oe[2:0] == 3'h0)
		else $error("timer input pin driven");
	pai_follow_a: assert property ($past(rst_b) && timer_pins_in[7] == $past(timer_pins_in[7]) &&
		timer_pins_in[7] == $past(timer_pins_in[7], 2) |-> pulse_accumulator_input == timer_pins_in[7])
		else $error("accumulator input not pin 7");
	strobe_pulse_a: assert property (wr_high_port && strobed_mode && !handshake_mode &&
		out_strobe_active_high && !expanded_q && $past(rst_b, 3) ##1 !wr_high_port
		|-> output_strobe_pin ##1 !output_strobe_pin) else $error("no single strobe pulse");
	high_write_a: assert property (wr_high_port && !expanded_q && $past(rst_b, 3)
		|-> ##2 high_pins_out == $past(wr_data, 2)) else $error("high port write not driven");
	addr_high_a: assert property (expanded_q && bus_cycle && $past(bus_cycle) && $past(bus_cycle, 2) &&
		$stable(bus_addr) && bus_addr == $past(bus_addr, 2) |-> high_pins_out == bus_addr[15:8])
		else $error("high address byte wrong");
	open_drain_a: assert property (!expanded_q && open_drain_select && $past(open_drain_select) &&
		$past(open_drain_select, 2) |-> (mux_pins_oe & mux_pins_out) == 8'h00) else $error("open drain drives high");
	dir_reset_a: assert property (!$past(rst_b, 2) |-> (timer_pins_oe & 8'h88) == 8'h00)
		else $error("direction not input after reset");
endmodule
bind mdpm_port_mux mdpm_port_mux_asserts i_mdpm_port_mux_asserts (.*);

// file: verif/testbench.sv
// Self-checking bench for the port pin multiplexer.
// Assumes the external memory model on the multiplexed bus.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
	reg        clk, rst_b, mode_select_low, mode_select_high, open_drain_select, strobed_mode, handshake_mode;
	reg        strobe_edge_rising, out_strobe_active_high, shared_is_compare, sci_enable, sci_txd, spi_enable;
	reg        spi_master, spi_miso_out, spi_mosi_out, spi_sck_out, bus_cycle, bus_phase_clk, bus_write;
	reg        input_strobe_pin;
	reg  [6:0] wr_sel;
	reg  [7:0] wr_data, timer_oc_en, timer_oc_val, bus_wdata, timer_ext, analog_pins_in, gpio_level;
	reg  [15:0] bus_addr;
	reg  [5:0] serial_pins_in;
	wire       wr_timer_port = wr_sel[0], wr_accum_ctl = wr_sel[1], wr_high_port = wr_sel[2];
	wire       wr_mux_port = wr_sel[3], wr_mux_dir = wr_sel[4], wr_serial_port = wr_sel[5], wr_serial_dir = wr_sel[6];
	wire [7:0] timer_pins_out, timer_pins_oe, high_pins_out, mux_pins_out, mux_pins_oe, mux_pins_in;
	wire [7:0] timer_port_rd_q, high_port_rd_q, mux_port_rd_q, latched_input_register, analog_port_rd_q;
	wire [7:0] capture_inputs, bus_rdata_q;
	// Timer pins read back what the block drives, else the outside level
	wire [7:0] timer_pins_in = (timer_pins_oe & timer_pins_out) | (~timer_pins_oe & timer_ext);
	wire [5:0] serial_pins_out, serial_pins_oe, serial_port_rd_q;
	wire [1:0] mode_q;
	wire       output_strobe_pin, address_latch_strobe, pulse_accumulator_input, expanded_q, special_q;
	wire       bus_data_valid_q, high_port_external_q, handshake_flag_q;
	integer    compares = 0;
	integer    miscompares = 0;
	mdpm_port_mux i_mdpm_port_mux (.*);
	mdpm_ext_mem i_mdpm_ext_mem (.clk(clk), .enable(expanded_q), .address_latch_strobe(address_latch_strobe),
		.output_strobe_pin(output_strobe_pin), .bus_phase_clk(bus_phase_clk), .mux_pins_out(mux_pins_out),
		.gpio_level(gpio_level), .mux_pins_in(mux_pins_in));
	always #10 clk = ~clk;
	task ck(input integer n);
		begin
			repeat (n) @(posedge clk);
			@(negedge clk);
		end
	endtask
	task start(input [1:0] m);
		begin
			@(posedge clk);
			rst_b <= 1'b0;
			{mode_select_high, mode_select_low} <= m;
			repeat (12) @(posedge clk);
			rst_b <= 1'b1;
			ck(2);
		end
	endtask
	task wr(input integer s, input [7:0] d);
		begin
			@(posedge clk);
			wr_sel[s] <= 1'b1;
			wr_data <= d;
			@(posedge clk);
			wr_sel <= 7'h00;
			ck(3);
		end
	endtask
	task bus(input [15:0] a, input w, input [7:0] d);
		begin
			@(posedge clk);
			{bus_cycle, bus_phase_clk, bus_addr, bus_write, bus_wdata} <= {2'h2, a, w, d};
			ck(3);
			`CHK({high_pins_out, mux_pins_out, address_latch_strobe}, {a, 1'b1})
			`CHK(output_strobe_pin, !w)
			@(posedge clk);
			bus_phase_clk <= 1'b1;
			ck(3);
			`CHK(mux_pins_oe, w ? 8'hff : 8'h00)
			`CHK(bus_data_valid_q, !w)
			if (w) `CHK(mux_pins_out, d)
			@(posedge clk);
			bus_phase_clk <= 1'b0;
			ck(2);
			if (!w) `CHK(bus_rdata_q, d)
		end
	endtask
	task test_modes;
		integer m;
		begin
			for (m = 0; m < 4; m++) begin
				start(m[1:0]);
				@(posedge clk);
				{mode_select_high, mode_select_low} <= ~m[1:0];
				ck(2);
				`CHK(mode_q, m[1:0])
				`CHK({expanded_q, special_q}, {m[1], ~m[0]})
			end
			$display("test_modes done");
		end
	endtask
	task test_timer;
		begin
			start(2'h1);
			`CHK(timer_pins_oe & 8'h88, 8'h00)
			@(posedge clk);
			{timer_ext, timer_oc_en, timer_oc_val} <= {8'h85, 8'h40, 8'h40};
			wr(1, 8'h88);
			wr(0, 8'hff);
			`CHK(timer_pins_oe & 8'h8f, 8'h88)
			`CHK({timer_pins_oe[6], timer_pins_out[7:6], timer_pins_out[3]}, 4'hf)
			`CHK(timer_port_rd_q & 8'h8f, 8'h8d)
			`CHK({pulse_accumulator_input, capture_inputs}, {1'b1, 8'h0d})
			wr(0, 8'h00);
			`CHK({timer_pins_out[7:6], timer_pins_out[3], pulse_accumulator_input}, 4'h4)
			$display("test_timer done");
		end
	endtask
	task test_ports;
		begin
			start(2'h1);
			@(posedge clk);
			{strobed_mode, gpio_level} <= {1'b1, 8'h3c};
			wr_sel[2] <= 1'b1;
			wr_data <= 8'h5a;
			@(posedge clk);
			wr_sel <= 7'h00;
			@(negedge clk);
			`CHK(output_strobe_pin, 1'b1)
			ck(2);
			`CHK({high_pins_out, high_port_rd_q, output_strobe_pin}, {16'h5a5a, 1'b0})
			@(posedge clk);
			handshake_mode <= 1'b1;
			input_strobe_pin <= 1'b1;
			ck(4);
			`CHK({latched_input_register, handshake_flag_q, output_strobe_pin}, {8'h3c, 2'h3})
			`CHK(mux_port_rd_q, 8'h3c)
			@(posedge clk);
			open_drain_select <= 1'b1;
			wr(3, 8'h0f);
			wr(4, 8'hff);
			`CHK({handshake_flag_q, output_strobe_pin}, 2'h0)
			`CHK({mux_pins_oe, mux_pins_out & mux_pins_oe}, 16'hf000)
			@(posedge clk);
			{sci_enable, sci_txd, spi_enable, spi_master, spi_mosi_out} <= 5'h1f;
			{analog_pins_in, serial_pins_in} <= {8'ha5, 6'h2a};
			ck(3);
			`CHK({serial_pins_oe[1:0], serial_pins_out[1]}, 3'h5)
			`CHK({serial_pins_oe[5], serial_pins_oe[3], serial_pins_out[3]}, 3'h3)
			`CHK({analog_port_rd_q, serial_port_rd_q}, {8'ha5, 6'h2a})
			$display("test_ports done");
		end
	endtask
	task test_bus;
		begin
			start(2'h3);
			bus(16'h8042, 1'b1, 8'hc3);
			bus(16'h8043, 1'b1, 8'h3c);
			bus(16'h8042, 1'b0, 8'hc3);
			bus(16'h8043, 1'b0, 8'h3c);
			@(posedge clk);
			bus_cycle <= 1'b0;
			wr(2, 8'h11);
			`CHK({high_port_external_q, high_port_rd_q, high_pins_out}, {1'b1, 8'h00, 8'h80})
			$display("test_bus done");
		end
	endtask
	task summarize;
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		{clk, rst_b, mode_select_low, mode_select_high, open_drain_select, strobed_mode, handshake_mode} = 7'h00;
		{shared_is_compare, sci_enable, sci_txd, spi_enable, spi_master, spi_miso_out, spi_mosi_out} = 7'h00;
		{spi_sck_out, bus_cycle, bus_phase_clk, bus_write, input_strobe_pin, wr_sel} = 12'h000;
		{wr_data, timer_oc_en, timer_oc_val, bus_wdata, timer_ext, analog_pins_in, gpio_level} = 56'h0;
		{bus_addr, serial_pins_in, strobe_edge_rising, out_strobe_active_high} = 24'h000003;
		test_modes;
		test_timer;
		test_ports;
		test_bus;
		summarize;
	end
	initial begin
		#100000;
		miscompares++;
		summarize;
	end
endmodule
